// >>> common/four_port_params.svh
`ifndef FOUR_PORT_PARAMS_SVH
`define FOUR_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index.
// ----------------------------------------------------------------
`define FP_IDX_W 14
`define FP_IDX_DATA_A 14'h0000
`define FP_IDX_DATA_B 14'h0001
`define FP_IDX_DATA_C 14'h0002
`define FP_IDX_DATA_D 14'h0003
`define FP_IDX_DIR_A 14'h0004
`define FP_IDX_DIR_B 14'h0005
`define FP_IDX_DIR_C 14'h0006
`define FP_IDX_DIR_D 14'h0007
`define FP_IDX_OPTION 14'h3fdf

// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define FP_DIR8_RESET 8'h00
`define FP_DIR7_RESET 7'h00
`define FP_OPT_SENS_BIT 1
`define FP_OPT_SENS_RESET 1'b1
`define FP_EDGE_REF_RESET 8'hff
`define FP_RD_ZERO 32'h0000_0000
`define FP_D_ASYNC_LO 0
`define FP_D_SPI_LO 2

`endif

// >>> common/four_port_pkg.sv
`default_nettype none
package four_port_pkg;

	// Pin or register bundle covering all four ports.
	typedef struct packed {
		logic [6:0] d;
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} port_bus_t;

	// Shared-function drive of the narrow port.
	typedef struct packed {
		logic [3:0] spiOe;
		logic [3:0] spiOut;
		logic [1:0] asyncOe;
		logic [1:0] asyncOut;
	} special_drive_t;

endpackage
`default_nettype wire

// >>> logic/four_port_parallel_io.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "four_port_params.svh"

module four_port_parallel_io #(
	parameter logic [7:0] INT_OPTION = 8'hff
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [15:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire four_port_pkg::port_bus_t pinIn,
	output four_port_pkg::port_bus_t pinOut,
	output four_port_pkg::port_bus_t pinOe,
	output logic [7:0] pullupEn,
	input wire four_port_pkg::special_drive_t special,
	output logic portIrqReq,
	output logic edgeAndLevel
);

	// ----------------------------------------------------------------
	// Bus slave.
	// ----------------------------------------------------------------
	logic ack_r;
	logic ack_nxt;
	logic [31:0] readdata_r;
	logic [31:0] readdata_nxt;
	logic request;
	logic writeTake;
	logic [`FP_IDX_W-1:0] index;
	logic [7:0] wrByte;

	// ----------------------------------------------------------------
	// Port registers.
	// ----------------------------------------------------------------
	four_port_pkg::port_bus_t data_r;
	four_port_pkg::port_bus_t data_nxt;
	four_port_pkg::port_bus_t dir_r;
	four_port_pkg::port_bus_t dir_nxt;
	four_port_pkg::port_bus_t pinSample_r;
	four_port_pkg::port_bus_t readView;
	logic sens_r;
	logic sens_nxt;
	logic sensLocked_r;
	logic sensLocked_nxt;

	// ----------------------------------------------------------------
	// Interrupt source state.
	// ----------------------------------------------------------------
	logic [7:0] prevB_r;
	logic [7:0] prevB_nxt;
	logic irq_r;
	logic irq_nxt;
	logic [7:0] srcEn;
	logic [7:0] fallB;
	logic anyLow;

	assign request = read | write;
	assign index = address[15:2];
	assign wrByte = writedata[7:0];
	assign writeTake = write & ack_r & byteenable[0];
	assign waitrequest = request & ~ack_r;
	assign readdata = readdata_r;

	always_comb
	begin
		readView = (data_r & dir_r) | (pinSample_r & ~dir_r);
	end

	always_comb
	begin
		ack_nxt = request & ~ack_r;
		readdata_nxt = readdata_r;
		if (read & ~ack_r)
		begin
			readdata_nxt = `FP_RD_ZERO;
			unique case (index)
				`FP_IDX_DATA_A: readdata_nxt[7:0] = readView.a;
				`FP_IDX_DATA_B: readdata_nxt[7:0] = readView.b;
				`FP_IDX_DATA_C: readdata_nxt[7:0] = readView.c;
				`FP_IDX_DATA_D: readdata_nxt[6:0] = readView.d;
				`FP_IDX_DIR_A: readdata_nxt[7:0] = dir_r.a;
				`FP_IDX_DIR_B: readdata_nxt[7:0] = dir_r.b;
				`FP_IDX_DIR_C: readdata_nxt[7:0] = dir_r.c;
				`FP_IDX_DIR_D: readdata_nxt[6:0] = dir_r.d;
				`FP_IDX_OPTION: readdata_nxt[`FP_OPT_SENS_BIT] = sens_r;
				default: readdata_nxt = `FP_RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			ack_r <= 1'b0;
			readdata_r <= `FP_RD_ZERO;
		end
		else
		begin
			ack_r <= ack_nxt;
			readdata_r <= readdata_nxt;
		end
	end

	always_comb
	begin
		data_nxt = data_r;
		dir_nxt = dir_r;
		sens_nxt = sens_r;
		sensLocked_nxt = sensLocked_r;
		if (writeTake)
		begin
			unique case (index)
				`FP_IDX_DATA_A: data_nxt.a = wrByte;
				`FP_IDX_DATA_B: data_nxt.b = wrByte;
				`FP_IDX_DATA_C: data_nxt.c = wrByte;
				`FP_IDX_DATA_D: data_nxt.d = wrByte[6:0];
				`FP_IDX_DIR_A: dir_nxt.a = wrByte;
				`FP_IDX_DIR_B: dir_nxt.b = wrByte;
				`FP_IDX_DIR_C: dir_nxt.c = wrByte;
				`FP_IDX_DIR_D: dir_nxt.d = wrByte[6:0];
				`FP_IDX_OPTION:
				begin
					if (!sensLocked_r)
					begin
						sens_nxt = wrByte[`FP_OPT_SENS_BIT];
						sensLocked_nxt = 1'b1;
					end
				end
				default: data_nxt = data_r;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		data_r <= data_nxt;
		pinSample_r <= pinIn;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			dir_r <= {`FP_DIR7_RESET, `FP_DIR8_RESET, `FP_DIR8_RESET,
				`FP_DIR8_RESET};
			sens_r <= `FP_OPT_SENS_RESET;
			sensLocked_r <= 1'b0;
		end
		else
		begin
			dir_r <= dir_nxt;
			sens_r <= sens_nxt;
			sensLocked_r <= sensLocked_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive.
	// ----------------------------------------------------------------
	// direction control
	always_comb
	begin
		pinOut = data_r;
		pinOe = reset_n ? dir_r : '0;
		if (reset_n)
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (special.asyncOe[i])
				begin
					pinOe.d[`FP_D_ASYNC_LO + i] = 1'b1;
					pinOut.d[`FP_D_ASYNC_LO + i] = special.asyncOut[i];
				end
			end
			for (int i = 0; i < 4; i++)
			begin
				if (special.spiOe[i])
				begin
					pinOe.d[`FP_D_SPI_LO + i] = 1'b1;
					pinOut.d[`FP_D_SPI_LO + i] = special.spiOut[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Second port interrupt sources.
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : gSrc
			assign srcEn[g] = INT_OPTION[g] & ~dir_r.b[g];
			assign pullupEn[g] = srcEn[g];
			assign fallB[g] = srcEn[g] & prevB_r[g] & ~pinIn.b[g];
		end
	endgenerate

	assign anyLow = |(srcEn & ~pinIn.b);
	assign edgeAndLevel = sens_r;
	assign portIrqReq = irq_r;

	always_comb
	begin
		prevB_nxt = pinIn.b;
		irq_nxt = (|fallB) | (sens_r & anyLow);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			prevB_r <= `FP_EDGE_REF_RESET;
			irq_r <= 1'b0;
		end
		else
		begin
			prevB_r <= prevB_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	dir_reset_clear_a: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		!reset_n |=> dir_r == '0)
		else $error("Direction not cleared by reset.");

	reset_no_drive_a: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		!reset_n |-> pinOe == '0)
		else $error("A pin driven during reset.");

	data_keep_reset_a: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		!reset_n && !writeTake |=> $stable(data_r))
		else $error("Data register changed by reset.");

	first_dir_write_a: assert property (
		writeTake && index == `FP_IDX_DIR_A |=> dir_r.a == $past(wrByte))
		else $error("First port direction write lost.");

	second_data_write_a: assert property (
		writeTake && index == `FP_IDX_DATA_B |=> data_r.b == $past(wrByte))
		else $error("Second port data write lost.");

	output_follows_data_a: assert property (
		dir_r.c[7] |-> pinOe.c[7] && pinOut.c[7] == data_r.c[7])
		else $error("Third port top line not driven from data.");

	pullup_input_only_a: assert property (
		dir_r.b[0] |-> !pullupEn[0])
		else $error("Pullup on while pin is output.");

	edge_raises_irq_a: assert property (
		|fallB |=> portIrqReq)
		else $error("Falling edge on source pin missed.");

	edge_only_mode_a: assert property (
		!sens_r && !(|fallB) |=> !portIrqReq)
		else $error("Level request in edge-only mode.");

	narrow_dir_read_a: assert property (
		read && !ack_r && index == `FP_IDX_DIR_D ##1 ack_r
		|-> readdata[6:0] == $past(dir_r.d) && readdata[31:7] == '0)
		else $error("Narrow direction readback wrong.");

	one_wait_state_a: assert property (
		request && !ack_r |=> !waitrequest)
		else $error("Bus answer not after one wait state.");

	second_dir_write_a: assert property (
		writeTake && index == `FP_IDX_DIR_B |=> dir_r.b == $past(wrByte))
		else $error("Second port direction write lost.");

	third_dir_write_a: assert property (
		writeTake && index == `FP_IDX_DIR_C |=> dir_r.c == $past(wrByte))
		else $error("Third port direction write lost.");

	narrow_data_write_a: assert property (
		writeTake && index == `FP_IDX_DATA_D
		|=> data_r.d == $past(wrByte[6:0]))
		else $error("Narrow port data write lost.");

	plain_first_port_a: assert property (
		pinOe.a == dir_r.a)
		else $error("First port drive not set by direction alone.");

	narrow_top_plain_a: assert property (
		pinOe.d[6] == dir_r.d[6])
		else $error("Unshared narrow line not set by direction.");

	shared_spi_drive_a: assert property (
		special.spiOe[0] |-> pinOe.d[`FP_D_SPI_LO]
		&& pinOut.d[`FP_D_SPI_LO] == special.spiOut[0])
		else $error("Shared line not handed to the SPI unit.");

	shared_async_drive_a: assert property (
		special.asyncOe[1] |-> pinOe.d[`FP_D_ASYNC_LO + 1]
		&& pinOut.d[`FP_D_ASYNC_LO + 1] == special.asyncOut[1])
		else $error("Shared line not handed to the async serial unit.");

	level_holds_irq_a: assert property (
		sens_r && anyLow |=> portIrqReq)
		else $error("Low source pin missed in level mode.");

	quiet_no_irq_a: assert property (
		!(|fallB) && !anyLow |=> !portIrqReq)
		else $error("Request raised with no source active.");

	sens_write_once_a: assert property (
		sensLocked_r |=> sens_r == $past(sens_r))
		else $error("Sensitivity bit changed after first write.");

	sens_reset_set_a: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		!reset_n |=> edgeAndLevel)
		else $error("Sensitivity not set by reset.");

	input_read_pin_a: assert property (
		read && !ack_r && index == `FP_IDX_DATA_A |=>
		((readdata[7:0] ^ $past(pinIn.a, 2)) & ~$past(dir_r.a)) == '0)
		else $error("Input bits of first port read wrong.");

endmodule

`default_nettype wire

// >>> tb/board_model.sv
`timescale 1ns/100ps
`default_nettype none
module board_model (
	input wire logic clk_sys,
	input wire four_port_pkg::port_bus_t pinOut,
	input wire four_port_pkg::port_bus_t pinOe,
	input wire logic [7:0] pullupEn,
	input wire four_port_pkg::port_bus_t extVal,
	input wire four_port_pkg::port_bus_t extEn,
	output four_port_pkg::port_bus_t pinIn
);
	four_port_pkg::port_bus_t flt = '0;
	four_port_pkg::port_bus_t pull;
	// Floating lines change every cycle.
	always @(posedge clk_sys)
	begin
		flt <= ~flt;
	end
	always_comb
	begin
		pull = '0;
		pull.b = pullupEn;
		pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
			| (~pinOe & ~extEn & (pull | flt));
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_sys = 0;
	logic reset_n = 0;
	logic [15:0] address = '0;
	logic read = 0;
	logic write = 0;
	logic [31:0] writedata = '0;
	logic [3:0] byteenable = 4'h1;
	logic [31:0] readdata;
	logic waitrequest;
	four_port_pkg::port_bus_t pinIn, pinOut, pinOe;
	four_port_pkg::port_bus_t extVal = '0;
	four_port_pkg::port_bus_t extEn = '0;
	four_port_pkg::special_drive_t special = '0;
	logic [7:0] pullupEn;
	logic portIrqReq;
	logic edgeAndLevel;
	logic [31:0] q;
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	always #12.5 clk_sys = ~clk_sys;
	four_port_parallel_io four_port_parallel_io_i (.clk_sys(clk_sys),
		.reset_n(reset_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
		.special(special), .portIrqReq(portIrqReq),
		.edgeAndLevel(edgeAndLevel));
	board_model board_model_i (.clk_sys(clk_sys), .pinOut(pinOut),
		.pinOe(pinOe), .pullupEn(pullupEn), .extVal(extVal),
		.extEn(extEn), .pinIn(pinIn));
	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic wrap_up;
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge clk_sys);
		address <= a;
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		@(posedge clk_sys);
		while (waitrequest !== 1'b0)
			@(posedge clk_sys);
		q = readdata;
		read <= 0;
		write <= 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e,
		input string nm);
		bus(0, a, 8'h00);
		chk(nm, {24'h0, e}, q);
	endtask
	task automatic cnt;
		n = 0;
		repeat (8)
		begin
			@(negedge clk_sys);
			n += (portIrqReq === 1'b1);
		end
	endtask
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_reset;
		@(negedge clk_sys);
		chk("oe", 0, pinOe);
		for (int p = 0; p < 4; p++)
			rd(16'(16 + 4 * p), 8'h00, "dir");
	endtask
	task automatic t_out;
		for (int p = 0; p < 4; p++)
		begin
			bus(1, 16'(4 * p), 8'ha5 ^ 8'(p));
			bus(1, 16'(16 + 4 * p), 8'hff);
			rd(16'(16 + 4 * p), p == 3 ? 8'h7f : 8'hff, "dir");
			rd(16'(4 * p), 8'(p == 3 ? 8'h26 : 8'ha5 ^ p), "data");
		end
		@(negedge clk_sys);
		chk("oe", 31'h7fffffff, pinOe);
		chk("out", 31'h26a7a4a5, pinOut);
		rd(16'h0020, 8'h00, "unmapped");
	endtask
	task automatic t_in;
		for (int p = 0; p < 4; p++)
			bus(1, 16'(16 + 4 * p), 8'h0f);
		extEn <= 31'h70f0f0f0;
		extVal <= 31'h3c3c3c3c;
		for (int p = 0; p < 4; p++)
			rd(16'(4 * p), 8'h30 | (8'h05 ^ 8'(p)), "mix");
		chk("pull", 8'hf0, pullupEn);
	endtask
	task automatic t_irq;
		bus(1, 16'h0004, 8'hff);
		bus(1, 16'h0014, 8'h00);
		extEn.b <= 8'hff;
		extVal.b <= 8'hff;
		@(negedge clk_sys);
		chk("pull", 8'hff, pullupEn);
		chk("sens", 1, edgeAndLevel);
		@(posedge clk_sys);
		extVal.b <= 8'hf7;
		cnt;
		chk("level", 1, 32'(n > 4));
		@(posedge clk_sys);
		extVal.b <= 8'hff;
		repeat (3) @(negedge clk_sys);
		chk("idle", 0, portIrqReq);
		rd(16'hff7c, 8'h02, "opt");
		bus(1, 16'hff7c, 8'h00);
		bus(1, 16'hff7c, 8'h02);
		@(negedge clk_sys);
		chk("sens", 0, edgeAndLevel);
		rd(16'hff7c, 8'h00, "opt");
		@(posedge clk_sys);
		extVal.b <= 8'hf7;
		cnt;
		chk("edge", 1, n);
	endtask
	task automatic t_rst;
		@(posedge clk_sys);
		special <= 12'hf5e;
		@(negedge clk_sys);
		chk("spOe", 6'h3f, pinOe.d[5:0]);
		chk("spOut", 6'h16, pinOut.d[5:0]);
		@(posedge clk_sys);
		reset_n <= 0;
		@(negedge clk_sys);
		chk("rstOe", 0, pinOe);
		repeat (2) @(posedge clk_sys);
		reset_n <= 1;
		special <= '0;
		rd(16'h0010, 8'h00, "dir");
		chk("sensRst", 1, edgeAndLevel);
		bus(1, 16'h0010, 8'hff);
		@(negedge clk_sys);
		chk("kept", 8'ha5, pinOut.a);
		chk("keptOe", 8'hff, pinOe.a);
		@(posedge clk_sys);
		byteenable <= 4'h0;
		bus(1, 16'h0010, 8'h00);
		byteenable <= 4'h1;
		rd(16'h0010, 8'hff, "beOff");
	endtask
	initial
	begin
		repeat (6) @(posedge clk_sys);
		reset_n <= 1;
		t_reset;
		t_out;
		t_in;
		t_irq;
		t_rst;
		wrap_up;
	end
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		wrap_up;
	end
endmodule
`default_nettype wire
